/* File: common/dvc_pkg.sv */
`default_nettype none
package dvc_pkg;
	// Clock and converter timing
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned SAR_TICK_NS = 1000;
	localparam int unsigned SAR_TICK_CYCLES = (SAR_TICK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned VOL_IVL_BASE = 8;

	// Register pages and offsets
	localparam logic [7:0] PAGE_MAIN = 8'h00;
	localparam logic [7:0] PAGE_COEF = 8'h09;
	localparam logic [7:0] REG_STATUS = 8'h26;
	localparam logic [7:0] REG_STICKY = 8'h2c;
	localparam logic [7:0] REG_LIVE = 8'h2e;
	localparam logic [7:0] REG_FILT = 8'h3c;
	localparam logic [7:0] REG_STEP = 8'h3f;
	localparam logic [7:0] REG_MUTE = 8'h40;
	localparam logic [7:0] REG_LEFT = 8'h41;
	localparam logic [7:0] REG_RIGHT = 8'h42;
	localparam logic [7:0] REG_COMP = 8'h44;
	localparam logic [7:0] REG_RATE = 8'h46;
	localparam logic [7:0] REG_PIN = 8'h74;
	localparam logic [7:0] REG_PINGAIN = 8'h75;
	localparam logic [7:0] COEF_FIRST = 8'h0e;
	localparam logic [7:0] COEF_LAST = 8'h19;

	// Field positions
	localparam int MUTE_L_BIT = 3;
	localparam int MUTE_R_BIT = 2;
	localparam int STATUS_DONE_R_BIT = 4;
	localparam int PIN_MODE_BIT = 7;
	localparam int PIN_CLK_BIT = 6;
	localparam logic [1:0] MASTER_LEFT = 2'h1;
	localparam logic [1:0] MASTER_RIGHT = 2'h2;
	localparam logic [1:0] STEP_FULL = 2'h0;
	localparam logic [1:0] STEP_HALF = 2'h1;
	localparam logic [1:0] FILT_B = 2'h2;
	localparam logic [1:0] FILT_C = 2'h3;

	// Reset values
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam logic [1:0] STEP_RESET = 2'h0;
	localparam logic [3:0] MUTE_RESET = 4'h0;
	localparam logic [7:0] COMP_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h00;
	localparam logic [7:0] PIN_RESET = 8'h00;
	localparam logic [1:0] FILT_RESET = 2'h0;
	localparam logic [15:0] COEF_RESET [6] = '{16'h7fab, 16'h8055, 16'h7f56, 16'h0011, 16'h0011, 16'h7fde};

	// Interpolation group delays, in samples
	localparam int DLY_A = 21;
	localparam int DLY_B = 18;
	localparam int DLY_C = 13;
	localparam int DLY_MAX = 21;

	// Data path
	localparam int SAMPLE_W = 16;
	localparam int FIFO_DEPTH = 32;

	// Gain arithmetic, q = 1/8 dB units
	localparam logic signed [7:0] GAIN_MAX_HALF = 8'sd48;
	localparam logic signed [7:0] GAIN_MIN_HALF = -8'sd127;
	localparam logic signed [11:0] MUTE_Q = -12'sd512;
	localparam logic signed [11:0] GAIN_Q_OFFSET = 12'sd768;
	localparam int Q_PER_OCT = 48;
	localparam int MANT_ONE = 16384;
	localparam int MANT_SLOPE = 341;
	localparam int GAIN_SHIFT = 30;
	localparam logic signed [11:0] LEVEL_FLOOR = -12'sd768;
	localparam int THR_STEP_Q = 24;
	localparam int HYST_STEP_Q = 8;

	// Pin converter mapping
	localparam logic [6:0] PIN_KNEE = 7'h5a;
	localparam logic [6:0] PIN_MUTE_CODE = 7'h7f;
	localparam int PIN_TOP_HALF = 36;
	localparam int PIN_LOW_BASE = 126;

	// Compressor gain, units of 2^-20 dB
	localparam int CG_FRAC = 17;
	localparam logic signed [27:0] CG_ATTACK_MAX = 28'sh0400000;
	localparam logic signed [27:0] CG_DECAY_MAX = 28'sh0000666;
	localparam logic signed [27:0] CG_FLOOR = -28'sh1800000;

	typedef enum logic {SAR_WAIT, SAR_CONV} dvc_sar_e;
endpackage
`default_nettype wire

/* File: hdl/dvc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module dvc_fifo
	#(
	parameter int W = 32,
	parameter int DEPTH = 32
	)
	(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
	);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_comb
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	// DEPTH must be a power of two: pointers wrap naturally
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready <= next_count != FULL_COUNT;
			out_valid <= next_count != '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule // dvc_fifo
`default_nettype wire

/* File: hdl/dvc_top.sv */
// Contract
// R1: Filter choice A, up to 48 ksps, delays output by 21 samples.
// R2: Filter choice B, up to 96 ksps, delays output by 18 samples.
// R3: Filter choice C, for 192 ksps, delays output by 13 samples.
// R4: Each channel gain independent, +24 dB to -63.5 dB in half-dB steps.
// R5: Left target gain from register 65 all bits, right from 66.
// R6: Register 64 low nibble holds per-channel mute and master gain mode.
// R7: Applied gain walks 0.125 dB per sample toward target until equal.
// R8: Register 63 low bits pick full-rate, half-rate or no stepping.
// R9: Volume registers rule gain unless register 116 bit 7 selects pin.
// R10: Register 38 bit 4 reads one when right gain has settled.
// R11: Host keeps codec_core_clock running until DAC power-up flag clears.
// R12: In pin mode a 7-bit SAR converts the pin, overwriting target gain.
// R13: Register 117 low seven bits read the last pin converter code.
// R14: Register 116 bit 6 picks converter clock, bits 2-0 update rate.
// R15: Codes 0..90 give +18..-27 dB, 91..126 -28..-63 dB, 127 mutes.
// R16: Compressor watches volume output and lowers or restores the gain.
// R17: Register 68 bits 6-5 enable the compressor per channel.
// R18: Energy path is first-order IIR high-pass then low-pass, scaled 2^15.
// R19: Six signed 16-bit coefficients live on page 9 registers 14-25.
// R20: High-pass output feeds the audio path; abs low-pass is energy. Code passes high-pass only with compressor on, else volume output.
// R21: Register 68 bits 4-2 set threshold -3 to -24 dBFS, 3 dB steps.
// R22: Over-threshold sets sticky register 44 flags, clear on read; live in 46.
// R23: Volume codes are signed half-dB, clamped to the legal range.
// R24: Register 68 bits 1-0 set hysteresis 0 to 3 dB; zero disables.
// R25: Register 70 high nibble sets per-sample attack reduction.
// R26: Register 70 low nibble sets per-sample decay increase.
`timescale 1ns/1ps
`default_nettype none
module dvc_top
	import dvc_pkg::*;
	(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [SAMPLE_W-1:0] in_left,
	input wire logic [SAMPLE_W-1:0] in_right,
	output logic out_valid,
	input wire logic out_ready,
	output logic [SAMPLE_W-1:0] out_left,
	output logic [SAMPLE_W-1:0] out_right,
	input wire logic vol_cmp,
	input wire logic vol_alt_tick,
	output logic [6:0] vol_trial
	);

	function automatic logic signed [11:0] half_to_q(input logic [7:0] v);
		logic signed [7:0] h;
		h = $signed(v);
		if (h > GAIN_MAX_HALF) // R23
			h = GAIN_MAX_HALF;
		else if (h < GAIN_MIN_HALF)
			h = GAIN_MIN_HALF;
		return {{2{h[7]}}, h, 2'b00}; // R4
	endfunction

	function automatic logic signed [11:0] step_toward(input logic signed [11:0] a, input logic signed [11:0] t);
		if (a < t)
			return a + 12'sd1; // R7
		else if (a > t)
			return a - 12'sd1;
		return a;
	endfunction

	// Piecewise-linear 2^x: cheap, within about 0.5 dB of exact
	function automatic logic signed [15:0] apply_gain(input logic signed [15:0] s, input logic signed [11:0] q);
		logic [10:0] off;
		logic [4:0] oct;
		logic [5:0] fr;
		logic signed [16:0] mant;
		logic signed [55:0] acc;
		off = 11'(q + GAIN_Q_OFFSET);
		oct = 5'(off / 11'(Q_PER_OCT));
		fr = 6'(off % 11'(Q_PER_OCT));
		mant = 17'(MANT_ONE + int'(fr) * MANT_SLOPE);
		acc = 56'(s * mant) <<< oct;
		acc = acc >>> GAIN_SHIFT;
		if (acc > 56'sd32767)
			return 16'sh7fff;
		else if (acc < -56'sd32768)
			return 16'sh8000;
		return 16'(acc);
	endfunction

	function automatic logic signed [15:0] iir_step(input logic signed [15:0] x, input logic signed [15:0] xp,
		input logic signed [15:0] yp, input logic signed [15:0] n0, input logic signed [15:0] n1,
		input logic signed [15:0] d1);
		logic signed [33:0] acc;
		acc = 34'(x * n0) + 34'(xp * n1) + 34'(yp * d1); // R18
		acc = acc >>> 15;
		if (acc > 34'sd32767)
			return 16'sh7fff;
		else if (acc < -34'sd32768)
			return 16'sh8000;
		return 16'(acc);
	endfunction

	function automatic logic signed [11:0] level_q(input logic [15:0] m);
		logic [3:0] p;
		logic [15:0] n;
		p = 4'h0;
		for (int i = 0; i < 16; i++)
			if (m[i])
				p = 4'(i);
		n = m << (4'hf - p);
		if (m == 16'h0000)
			return LEVEL_FLOOR;
		return 12'(int'(p) * Q_PER_OCT - 15 * Q_PER_OCT + int'(n[14:11]) * 3);
	endfunction

	function automatic logic signed [7:0] pin_to_half(input logic [6:0] c);
		if (c <= PIN_KNEE)
			return 8'(PIN_TOP_HALF - int'(c)); // R15
		return 8'(PIN_LOW_BASE - 2 * int'(c));
	endfunction

	logic [7:0] left_channel_target_gain;
	logic [7:0] right_channel_target_gain;
	logic [1:0] step_mode;
	logic [3:0] mute_ctl;
	logic [1:0] filt_sel;
	logic [1:0] comp_en;
	logic [2:0] comp_thr;
	logic [1:0] comp_hyst;
	logic [3:0] attack_rate;
	logic [3:0] decay_rate;
	logic pin_mode;
	logic pin_clk_sel;
	logic [2:0] pin_rate;
	logic [6:0] pin_gain_code;
	logic pin_mute;
	logic [15:0] coef [6];
	logic [1:0] sticky;
	logic [1:0] live;
	logic half_phase;

	logic signed [15:0] smp [2];
	logic signed [15:0] vol [2];
	logic signed [15:0] hp [2];
	logic signed [15:0] lp [2];
	logic signed [15:0] path [2];
	logic signed [15:0] x1 [2];
	logic signed [15:0] hp1 [2];
	logic signed [15:0] lp1 [2];
	logic signed [11:0] tgt [2];
	logic signed [11:0] app [2];
	logic signed [11:0] lev [2];
	logic signed [27:0] cg [2];
	logic [1:0] active;
	logic [1:0] over;
	logic [1:0] settled;
	logic [1:0] ch_en;
	logic [1:0] ch_mute;
	logic signed [11:0] thr_q;
	logic signed [11:0] hyst_q;
	logic [31:0] dline [DLY_MAX];
	logic [4:0] tap;
	logic [31:0] fifo_data;
	logic fifo_valid;
	logic take;
	logic [7:0] rd_mux;
	logic [2:0] coef_idx;
	logic sar_done;
	logic [6:0] sar_code;

	dvc_fifo #(.W(2 * SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(mclk),
		.rst_n(resetn),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data({in_right, in_left}),
		.out_valid(fifo_valid),
		.out_ready(out_ready),
		.out_data(fifo_data)
	);

	// A sample leaves the FIFO only while the sink accepts one
	assign take = fifo_valid && out_ready;
	assign coef_idx = 3'((reg_addr - COEF_FIRST) >> 1);

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			left_channel_target_gain <= GAIN_RESET;
			right_channel_target_gain <= GAIN_RESET;
			step_mode <= STEP_RESET;
			mute_ctl <= MUTE_RESET;
			filt_sel <= FILT_RESET;
			{comp_en, comp_thr, comp_hyst} <= COMP_RESET[6:0];
			{attack_rate, decay_rate} <= RATE_RESET;
			{pin_mode, pin_clk_sel, pin_rate} <= {PIN_RESET[7:6], PIN_RESET[2:0]};
			for (int i = 0; i < 6; i++)
				coef[i] <= COEF_RESET[i];
		end
		else
		begin
			if (reg_wr && reg_page == PAGE_MAIN)
			begin
				unique case (reg_addr)
					REG_LEFT: left_channel_target_gain <= reg_wdata; // R5
					REG_RIGHT: right_channel_target_gain <= reg_wdata; // R5
					REG_STEP: step_mode <= reg_wdata[1:0]; // R8
					REG_MUTE: mute_ctl <= reg_wdata[3:0]; // R6
					REG_FILT: filt_sel <= reg_wdata[1:0];
					REG_COMP: {comp_en, comp_thr, comp_hyst} <= reg_wdata[6:0]; // R17 R21 R24
					REG_RATE: {attack_rate, decay_rate} <= reg_wdata; // R25 R26
					REG_PIN: {pin_mode, pin_clk_sel, pin_rate} <= {reg_wdata[7:6], reg_wdata[2:0]}; // R9 R14
					default: ;
				endcase
			end
			if (reg_wr && reg_page == PAGE_COEF && reg_addr >= COEF_FIRST && reg_addr <= COEF_LAST)
			begin
				if (!reg_addr[0])
					coef[coef_idx][15:8] <= reg_wdata; // R19
				else
					coef[coef_idx][7:0] <= reg_wdata;
			end
			// Converter result lands after any same-cycle host write
			if (sar_done && pin_mode && sar_code != PIN_MUTE_CODE)
			begin
				left_channel_target_gain <= pin_to_half(sar_code); // R12
				right_channel_target_gain <= pin_to_half(sar_code);
			end
		end
	end

	always_comb
	begin
		thr_q = 12'(-THR_STEP_Q * (int'(comp_thr) + 1)); // R21
		hyst_q = 12'(HYST_STEP_Q * int'(comp_hyst)); // R24
		ch_en = {comp_en[0], comp_en[1]}; // R17
		ch_mute = {mute_ctl[MUTE_R_BIT], mute_ctl[MUTE_L_BIT]} | {2{pin_mute}};
		smp[0] = $signed(fifo_data[15:0]);
		smp[1] = $signed(fifo_data[31:16]);
		unique case (mute_ctl[1:0])
			MASTER_LEFT: tgt[0] = half_to_q(left_channel_target_gain); // R6
			MASTER_RIGHT: tgt[0] = half_to_q(right_channel_target_gain);
			default: tgt[0] = half_to_q(left_channel_target_gain);
		endcase
		unique case (mute_ctl[1:0])
			MASTER_LEFT: tgt[1] = half_to_q(left_channel_target_gain);
			MASTER_RIGHT: tgt[1] = half_to_q(right_channel_target_gain);
			default: tgt[1] = half_to_q(right_channel_target_gain);
		endcase
		for (int c = 0; c < 2; c++)
		begin
			if (ch_mute[c])
				tgt[c] = MUTE_Q;
			settled[c] = app[c] == tgt[c];
			if (app[c] == MUTE_Q)
				vol[c] = 16'sh0000;
			else
				vol[c] = apply_gain(smp[c], app[c] + 12'(cg[c] >>> CG_FRAC)); // R16
			hp[c] = iir_step(vol[c], x1[c], hp1[c], $signed(coef[0]), $signed(coef[1]), $signed(coef[2]));
			lp[c] = iir_step(hp[c], hp1[c], lp1[c], $signed(coef[3]), $signed(coef[4]), $signed(coef[5]));
			lev[c] = level_q(lp[c][15] ? 16'(-{lp[c][15], lp[c]}) : 16'(lp[c])); // R20
			over[c] = ch_en[c] && lev[c] > thr_q;
			path[c] = ch_en[c] ? hp[c] : vol[c]; // R20
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			half_phase <= 1'b0;
			for (int c = 0; c < 2; c++)
				app[c] <= MUTE_Q;
		end
		else if (take)
		begin
			half_phase <= !half_phase;
			for (int c = 0; c < 2; c++)
			begin
				if (step_mode == STEP_FULL || (step_mode == STEP_HALF && half_phase))
					app[c] <= step_toward(app[c], tgt[c]); // R7 R8
				else if (step_mode != STEP_FULL && step_mode != STEP_HALF)
					app[c] <= tgt[c]; // R8
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			active <= 2'b00;
			for (int c = 0; c < 2; c++)
			begin
				x1[c] <= 16'sh0000;
				hp1[c] <= 16'sh0000;
				lp1[c] <= 16'sh0000;
				cg[c] <= 28'sh0000000;
			end
		end
		else if (take)
		begin
			for (int c = 0; c < 2; c++)
			begin
				x1[c] <= vol[c];
				hp1[c] <= hp[c];
				lp1[c] <= lp[c];
				if (!ch_en[c])
				begin
					active[c] <= 1'b0;
					cg[c] <= 28'sh0000000;
				end
				else
				begin
					if (!active[c] && lev[c] > thr_q + hyst_q)
						active[c] <= 1'b1; // R24
					else if (active[c] && lev[c] < thr_q - hyst_q)
						active[c] <= 1'b0;
					if (active[c])
						cg[c] <= (cg[c] - (CG_ATTACK_MAX >>> attack_rate) < CG_FLOOR) ? CG_FLOOR
							: cg[c] - (CG_ATTACK_MAX >>> attack_rate); // R25
					else
						cg[c] <= (cg[c] + (CG_DECAY_MAX >>> decay_rate) > 28'sh0000000) ? 28'sh0000000
							: cg[c] + (CG_DECAY_MAX >>> decay_rate); // R26
				end
			end
		end
	end

	// Set beats the clear of a read in the same cycle
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			sticky <= 2'b00;
			live <= 2'b00;
		end
		else
		begin
			if (take)
				live <= over; // R22
			if (reg_rd && reg_page == PAGE_MAIN && reg_addr == REG_STICKY)
				sticky <= take ? over : 2'b00; // R22
			else if (take)
				sticky <= sticky | over; // R22
		end
	end

	always_comb
	begin
		unique case (filt_sel)
			FILT_B: tap = 5'(DLY_B - 1); // R2
			FILT_C: tap = 5'(DLY_C - 1); // R3
			default: tap = 5'(DLY_A - 1); // R1
		endcase
	end

	// Group delay modelled as a pure sample delay line
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			out_valid <= 1'b0;
			out_left <= '0;
			out_right <= '0;
			for (int i = 0; i < DLY_MAX; i++)
				dline[i] <= 32'h0000_0000;
		end
		else
		begin
			out_valid <= take;
			if (take)
			begin
				{out_right, out_left} <= dline[tap]; // R1 R2 R3
				dline[0] <= {path[1], path[0]};
				for (int i = 1; i < DLY_MAX; i++)
					dline[i] <= dline[i-1];
			end
		end
	end

	always_comb
	begin
		rd_mux = 8'h00;
		if (reg_page == PAGE_MAIN)
		begin
			unique case (reg_addr)
				REG_LEFT: rd_mux = left_channel_target_gain;
				REG_RIGHT: rd_mux = right_channel_target_gain;
				REG_STEP: rd_mux = {6'h00, step_mode};
				REG_MUTE: rd_mux = {4'h0, mute_ctl};
				REG_FILT: rd_mux = {6'h00, filt_sel};
				REG_COMP: rd_mux = {1'b0, comp_en, comp_thr, comp_hyst};
				REG_RATE: rd_mux = {attack_rate, decay_rate};
				REG_PIN: rd_mux = {pin_mode, pin_clk_sel, 3'h0, pin_rate};
				REG_PINGAIN: rd_mux = {1'b0, pin_gain_code}; // R13
				REG_STATUS: rd_mux = 8'(settled[1]) << STATUS_DONE_R_BIT; // R10
				REG_STICKY: rd_mux = {4'h0, sticky[0], sticky[1], 2'h0};
				REG_LIVE: rd_mux = {4'h0, live[0], live[1], 2'h0};
				default: rd_mux = 8'h00;
			endcase
		end
		else if (reg_page == PAGE_COEF && reg_addr >= COEF_FIRST && reg_addr <= COEF_LAST)
			rd_mux = reg_addr[0] ? coef[coef_idx][7:0] : coef[coef_idx][15:8]; // R19
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	// Volume pin converter
	dvc_sar_e sar_state;
	logic [$clog2(SAR_TICK_CYCLES)-1:0] div_cnt;
	logic div_tick;
	logic sar_tick;
	logic [10:0] wait_cnt;
	logic [2:0] bit_idx;

	assign sar_tick = pin_clk_sel ? vol_alt_tick : div_tick; // R14

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_cnt <= '0;
			div_tick <= 1'b0;
		end
		else
		begin
			div_tick <= div_cnt == ($clog2(SAR_TICK_CYCLES))'(SAR_TICK_CYCLES - 1);
			if (div_cnt == ($clog2(SAR_TICK_CYCLES))'(SAR_TICK_CYCLES - 1))
				div_cnt <= '0;
			else
				div_cnt <= div_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			sar_state <= SAR_WAIT;
			wait_cnt <= 11'h000;
			bit_idx <= 3'h6;
			vol_trial <= 7'h00;
			sar_done <= 1'b0;
			sar_code <= 7'h00;
		end
		else
		begin
			sar_done <= 1'b0;
			if (!pin_mode)
			begin
				sar_state <= SAR_WAIT; // R9
				wait_cnt <= 11'h000;
			end
			else if (sar_tick)
			begin
				unique case (sar_state)
					SAR_WAIT:
					begin
						if (wait_cnt == 11'h000)
						begin
							sar_state <= SAR_CONV;
							bit_idx <= 3'h6;
							vol_trial <= 7'h40;
						end
						else
							wait_cnt <= wait_cnt - 1'b1;
					end
					SAR_CONV:
					begin
						if (bit_idx == 3'h0)
						begin
							sar_code <= vol_cmp ? vol_trial : vol_trial & 7'h7e; // R12
							sar_done <= 1'b1;
							sar_state <= SAR_WAIT;
							wait_cnt <= 11'((VOL_IVL_BASE << pin_rate) - 1); // R14
						end
						else
						begin
							vol_trial <= (vol_cmp ? vol_trial : vol_trial & ~(7'h01 << bit_idx))
								| (7'h01 << (bit_idx - 3'h1));
							bit_idx <= bit_idx - 3'h1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_gain_code <= 7'h00;
			pin_mute <= 1'b0;
		end
		else if (!pin_mode)
			pin_mute <= 1'b0;
		else if (sar_done)
		begin
			pin_gain_code <= sar_code; // R13
			pin_mute <= sar_code == PIN_MUTE_CODE; // R15
		end
	end
endmodule // dvc_top
`default_nettype wire

/* File: sim/dvc_pot_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dvc_pot_model
	(
	input wire logic [6:0] pin_code,
	input wire logic [6:0] vol_trial,
	output logic vol_cmp
	);
	// Ideal comparator, pin voltage given as a code
	assign vol_cmp = pin_code >= vol_trial;
endmodule // dvc_pot_model
`default_nettype wire

/* File: sim/dvc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dvc_monitor
	import dvc_pkg::*;
	(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [SAMPLE_W-1:0] out_left,
	input wire logic [SAMPLE_W-1:0] out_right
	);
	logic seen;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			seen <= 1'h0;
		else if (in_valid && in_ready)
			seen <= 1'h1;
	end
	property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
	property p_out_hold; !out_valid |-> $stable(out_left) && $stable(out_right); endproperty
	a_out_hold: assert property (p_out_hold) else $error("output moved without valid");
	property p_outv_ready; out_valid |-> $past(out_ready); endproperty
	a_outv_ready: assert property (p_outv_ready) else $error("output without sink ready");
	property p_outv_seen; out_valid |-> $past(seen); endproperty
	a_outv_seen: assert property (p_outv_seen) else $error("output before any push");
	property p_full_stay; !in_ready && !out_ready && !$past(out_ready) |=> !in_ready; endproperty
	a_full_stay: assert property (p_full_stay) else $error("room appeared without a take");
	property p_room_stay; in_ready && !in_valid && !$past(in_valid) |=> in_ready; endproperty
	a_room_stay: assert property (p_room_stay) else $error("full without a push");
	property p_ready_fall; $fell(in_ready) |-> $past(in_valid) || $past(in_valid, 2); endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready fell with no push");
	property p_ready_rise; $rose(in_ready) |-> $past(out_ready) || $past(out_ready, 2); endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready rose with no take");
	c_read: cover property (reg_rd);
	c_take: cover property (out_valid && $past(out_valid));
	c_full: cover property (!in_ready);
endmodule // dvc_monitor
bind dvc_top dvc_monitor mon_u (.mclk, .resetn, .reg_rd, .reg_rdata, .in_valid, .in_ready, .out_valid,
	.out_ready, .out_left, .out_right);
`default_nettype wire

/* File: sim/dac_volume_and_compressor_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_volume_and_compressor_test;
	import dvc_pkg::*;
	logic mclk = '0, resetn = '0, reg_wr = '0, reg_rd = '0, in_valid = '0, out_ready = '1, vol_alt_tick = '0;
	logic [7:0] reg_page = '0, reg_addr = '0, reg_wdata = '0, reg_rdata, rv;
	logic [15:0] in_s = '0, out_left, out_right;
	logic out_valid, in_ready, vol_cmp;
	logic [6:0] vol_trial, pin_code = '0;
	logic [6:0] pcode [2] = '{7'h22, 7'h64};
	logic [7:0] pgain [2] = '{8'h02, 8'hb6};
	logic [23:0] rtab [7] = '{24'h004100, 24'h004200, 24'h004400, 24'h090e7f, 24'h090fab, 24'h0919de, 24'h000100};
	logic [23:0] wtab [4] = '{24'h004130, 24'h0042d0, 24'h007500, 24'h091012};
	logic [31:0] got [$];
	int n_mismatch = 0, num_checks = 0, cyc = 0, n, sz;
	always #4 mclk = ~mclk;
	dvc_top dut_u (.mclk, .resetn, .reg_page, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid,
		.in_ready, .in_left(in_s), .in_right(in_s), .out_valid, .out_ready, .out_left, .out_right, .vol_cmp,
		.vol_alt_tick, .vol_trial);
	dvc_pot_model pot_u (.pin_code, .vol_trial, .vol_cmp);
	always @(negedge mclk)
		if (out_valid === 1'h1)
			got.push_back({out_left, out_right});
	task automatic results();
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
		@(posedge mclk);
		reg_page <= pg;
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] pg, input logic [7:0] ad);
		@(posedge mclk);
		reg_page <= pg;
		reg_addr <= ad;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(negedge mclk);
		rv = reg_rdata;
	endtask
	task automatic rst();
		@(posedge mclk);
		resetn <= 1'h0;
		repeat (3) @(posedge mclk);
		resetn <= 1'h1;
		got.delete();
	endtask
	task automatic push(input logic [15:0] s);
		@(posedge mclk);
		in_s <= s;
		in_valid <= 1'h1;
		@(posedge mclk);
		in_valid <= 1'h0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic tick40();
		repeat (40)
		begin
			@(posedge mclk);
			vol_alt_tick <= 1'h1;
			@(posedge mclk);
			vol_alt_tick <= 1'h0;
			repeat (2) @(posedge mclk);
		end
	endtask
	task automatic stream(input logic [1:0] sel, input int dly);
		rst();
		wr(PAGE_MAIN, REG_STEP, 8'h02);
		wr(PAGE_MAIN, REG_FILT, {6'h00, sel});
		for (int k = 0; k < 32; k++)
			push(16'(k + 1));
		rd(PAGE_MAIN, REG_STATUS);
		chk("done_r", rv[STATUS_DONE_R_BIT], 1'h1);
		chk("count", got.size(), 32);
		chk("head", got[0], 32'h0);
		for (int k = dly + 4; k < 32; k++)
			chk("delay", got[k], {2{16'(k - dly + 1)}});
	endtask
	initial
	begin
		rst();
		rd(PAGE_MAIN, REG_STATUS);
		chk("done_r0", rv[STATUS_DONE_R_BIT], 1'h0);
		foreach (rtab[i])
		begin
			rd(rtab[i][23:16], rtab[i][15:8]);
			chk("reset", rv, rtab[i][7:0]);
		end
		foreach (wtab[i])
			wr(wtab[i][23:16], wtab[i][15:8], 8'h55 ^ wtab[i][7:0] ^ 8'h55 | (wtab[i][15:8] == REG_PINGAIN ? 8'h55 : 8'h00));
		@(posedge mclk);
		pin_code <= pcode[0];
		tick40();
		foreach (wtab[i])
		begin
			rd(wtab[i][23:16], wtab[i][15:8]);
			chk("rdback", rv, wtab[i][7:0]);
		end
		wr(PAGE_MAIN, REG_PIN, 8'hc0);
		for (int j = 0; j < 2; j++)
		begin
			@(posedge mclk);
			pin_code <= pcode[j];
			tick40();
			rd(PAGE_MAIN, REG_PINGAIN);
			chk("pin_code", rv, {1'h0, pcode[j]});
			rd(PAGE_MAIN, REG_LEFT);
			chk("pin_left", rv, pgain[j]);
			rd(PAGE_MAIN, REG_RIGHT);
			chk("pin_right", rv, pgain[j]);
		end
		stream(2'h0, DLY_A);
		stream(FILT_B, DLY_B);
		stream(FILT_C, DLY_C);
		wr(PAGE_MAIN, REG_MUTE, 8'h08);
		// Applied gain follows the target one sample late, plus the group delay
		repeat (15) push(16'h0100);
		chk("mute", got[$], 32'h00000100);
		@(posedge mclk);
		out_ready <= 1'h0;
		in_valid <= 1'h1;
		n = 0;
		repeat (40)
		begin
			@(negedge mclk);
			n += (in_ready === 1'h1);
		end
		chk("fill", n, 32);
		@(posedge mclk);
		in_valid <= 1'h0;
		out_ready <= 1'h1;
		sz = got.size();
		repeat (40) @(posedge mclk);
		chk("drain", got.size() - sz, 32);
		// Pass-through energy filters so the level is known
		for (int i = 0; i < 12; i++)
			wr(PAGE_COEF, 8'(COEF_FIRST + i), i % 6 == 0 ? 8'h7f : i % 6 == 1 ? 8'hff : 8'h00);
		wr(PAGE_MAIN, REG_COMP, 8'h20);
		push(16'h0400);
		rd(PAGE_MAIN, REG_STICKY);
		chk("quiet", rv, 8'h00);
		push(16'h7000);
		rd(PAGE_MAIN, REG_LIVE);
		chk("live", rv, 8'h04);
		rd(PAGE_MAIN, REG_STICKY);
		chk("sticky", rv, 8'h04);
		rd(PAGE_MAIN, REG_STICKY);
		chk("clear", rv, 8'h00);
		rst();
		wr(PAGE_MAIN, REG_RIGHT, 8'h80);
		repeat (3) push(16'h0000);
		rd(PAGE_MAIN, REG_STATUS);
		chk("step3", rv[STATUS_DONE_R_BIT], 1'h0);
		push(16'h0000);
		rd(PAGE_MAIN, REG_STATUS);
		chk("step4", rv[STATUS_DONE_R_BIT], 1'h1);
		wr(PAGE_MAIN, REG_STEP, {6'h00, STEP_HALF});
		wr(PAGE_MAIN, REG_RIGHT, 8'h82);
		repeat (6) push(16'h0000);
		rd(PAGE_MAIN, REG_STATUS);
		chk("half6", rv[STATUS_DONE_R_BIT], 1'h0);
		repeat (2) push(16'h0000);
		rd(PAGE_MAIN, REG_STATUS);
		chk("half8", rv[STATUS_DONE_R_BIT], 1'h1);
		results();
	end
endmodule // dac_volume_and_compressor_test
`default_nettype wire
